// ==== logic/rrdac_cfg.svh ====
// Constants for the ratiometric reference converter control block.
// Assumes an 8-bit register port with byte offsets as printed.
`ifndef RRDAC_CFG_SVH
`define RRDAC_CFG_SVH
// Register offsets
`define RRDAC_ADDR_W 12
`define RRDAC_CTRL_ADDR 12'hEC6
`define RRDAC_CODE_ADDR 12'hEC7
// Control register field positions
`define RRDAC_EN_BIT 7
`define RRDAC_OE_BIT 5
`define RRDAC_PSS_HI 3
`define RRDAC_PSS_LO 2
`define RRDAC_NSS_BIT 0
// Writable bit masks, unimplemented bits read zero
`define RRDAC_CTRL_MASK 8'hAD
`define RRDAC_CODE_MASK 8'h1F
// Reset values
`define RRDAC_CTRL_RST 8'h00
`define RRDAC_CODE_RST 5'h00
// Ladder size
`define RRDAC_LEVELS 32
`define RRDAC_LADDER_W 32
`endif

// ==== logic/rrdac_ladder.sv ====
// One-hot ladder tap decoder for the 32-level resistor ladder.
// Assumes a registered code; output is combinational.
`timescale 1ns/1ps
`include "rrdac_cfg.svh"
module rrdac_ladder (
   input wire logic enable_in,
   input wire logic [4:0] code_in,
   output logic [`RRDAC_LADDER_W-1:0] tap_out
);
   // Tap k gives Vneg + (Vpos-Vneg)*k/32; all off while disabled
   always_comb begin
      tap_out = '0;
      if (enable_in) begin
         tap_out[code_in] = 1'b1;
      end
   end
endmodule : rrdac_ladder

// ==== logic/rrdac_pkg.sv ====
// Types shared by the converter control block.
// Assumes the constants header is included by the design files.
package rrdac_pkg;
   // Positive source choices
   typedef enum logic [1:0] {
      RRDAC_PSS_AVDD = 2'h0,
      RRDAC_PSS_VREFP = 2'h1,
      RRDAC_PSS_FIXED = 2'h2,
      RRDAC_PSS_RSVD = 2'h3
   } rrdac_pss_t;
   // Fixed reference buffer gain
   typedef enum logic [1:0] {
      RRDAC_GAIN_OFF = 2'h0,
      RRDAC_GAIN_1X = 2'h1,
      RRDAC_GAIN_2X = 2'h2,
      RRDAC_GAIN_4X = 2'h3
   } rrdac_gain_t;
   // Registered state of the top module, apart from the synchronisers
   typedef struct packed {
      logic [7:0] ctrl;
      logic [4:0] code;
      logic [7:0] rdata;
      logic [31:0] ladder;
      logic pos_fixed;
      logic pos_vrefp;
      logic pos_avdd;
      logic neg_vrefn;
      logic pin_analog;
      logic pin_din;
      logic cmp_ref_sel;
      logic adc_ref_sel;
      logic [1:0] gain;
      logic fixed_on;
   } rrdac_state_t;
endpackage : rrdac_pkg

// ==== logic/rrdac_top.sv ====
// Control logic of the 5-bit ratiometric reference converter.
// Assumes a single 50 MHz clock, registers on a plain strobe port,
// and an analog ladder plus pad cell driven by the select outputs.
`timescale 1ns/1ps
`include "rrdac_cfg.svh"
module rrdac_top (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [`RRDAC_ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [1:0] comparator_ref_gain_in,
   input wire logic pad_din_in,
   input wire logic sleep_in,
   input wire logic cmp_use_ref_in,
   input wire logic adc_use_ref_in,
   output logic [7:0] rdata_out,
   output logic converter_on_out,
   output logic [`RRDAC_LADDER_W-1:0] ladder_sel_out,
   output logic pos_fixed_out,
   output logic pos_vrefp_out,
   output logic pos_avdd_out,
   output logic neg_vrefn_out,
   output logic first_ref_output_pin_out,
   output logic pad_driver_off_out,
   output logic pad_pullup_off_out,
   output logic pad_input_off_out,
   output logic pad_din_out,
   output logic cmp_ref_sel_out,
   output logic adc_ref_sel_out,
   output logic [1:0] fixed_gain_out,
   output logic fixed_on_out
);
   // ****************************************************************
   // State and helpers
   // ****************************************************************
   rrdac_pkg::rrdac_state_t state; // Registered state
   rrdac_pkg::rrdac_state_t next_state; // Next state copy
   logic [`RRDAC_LADDER_W-1:0] tap; // Decoded ladder tap
   logic din_meta; // Pad input, first stage only
   logic din_sync; // Pad input, second stage
   logic [1:0] gain_meta; // Gain field, first stage only
   logic [1:0] gain_sync; // Gain field, second stage

   // Masked register read so reserved bits always read as zero
   function automatic logic [7:0] rrdac_read(
      input logic [`RRDAC_ADDR_W-1:0] a,
      input logic [7:0] ctrl,
      input logic [4:0] code);
      logic [7:0] r;
      r = 8'h00;
      if (a == `RRDAC_CTRL_ADDR) begin
         r = ctrl & `RRDAC_CTRL_MASK;
      end else if (a == `RRDAC_CODE_ADDR) begin
         r = {3'h0, code};
      end
      return r;
   endfunction : rrdac_read

   // ****************************************************************
   // Tap decoder
   // ****************************************************************
   rrdac_ladder u_ladder (
      .enable_in(state.ctrl[`RRDAC_EN_BIT]),
      .code_in(state.code),
      .tap_out(tap)
   );

   // ****************************************************************
   // Synchronisers for inputs from outside the clock domain
   // ****************************************************************
   // Pad level and fixed-reference gain arrive from other logic
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         din_meta <= 1'b0;
         din_sync <= 1'b0;
         gain_meta <= 2'h0;
         gain_sync <= 2'h0;
      end else begin
         din_meta <= pad_din_in;
         din_sync <= din_meta;
         gain_meta <= comparator_ref_gain_in;
         gain_sync <= gain_meta;
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   // Sleep is deliberately unused: the converter keeps running and
   // nothing here is cleared on wake-up
   always_comb begin
      next_state = state;
      // Register writes; masked so unimplemented bits stay zero
      if (write_in) begin
         if (addr_in == `RRDAC_CTRL_ADDR) begin
            next_state.ctrl = wdata_in & `RRDAC_CTRL_MASK;
         end else if (addr_in == `RRDAC_CODE_ADDR) begin
            next_state.code = wdata_in[4:0];
         end
      end
      // Read data valid only the cycle after the strobe
      if (read_in) begin
         next_state.rdata = rrdac_read(addr_in, state.ctrl, state.code);
      end else begin
         next_state.rdata = 8'h00;
      end
      // Ladder tap from the current code, off while disabled
      next_state.ladder = tap;
      // Positive source; reserved code selects nothing
      next_state.pos_fixed = state.ctrl[`RRDAC_EN_BIT] &&
         (state.ctrl[`RRDAC_PSS_HI:`RRDAC_PSS_LO] ==
          rrdac_pkg::RRDAC_PSS_FIXED);
      next_state.pos_vrefp = state.ctrl[`RRDAC_EN_BIT] &&
         (state.ctrl[`RRDAC_PSS_HI:`RRDAC_PSS_LO] ==
          rrdac_pkg::RRDAC_PSS_VREFP);
      next_state.pos_avdd = state.ctrl[`RRDAC_EN_BIT] &&
         (state.ctrl[`RRDAC_PSS_HI:`RRDAC_PSS_LO] ==
          rrdac_pkg::RRDAC_PSS_AVDD);
      // Negative source: pin when set, analog ground when clear
      next_state.neg_vrefn = state.ctrl[`RRDAC_EN_BIT] &&
         state.ctrl[`RRDAC_NSS_BIT];
      // Pin override follows the output-enable bit; the pin is given over to
      // the analog level whether or not the ladder is powered
      next_state.pin_analog = state.ctrl[`RRDAC_OE_BIT];
      // Port read of an analog pin is forced low
      next_state.pin_din = state.ctrl[`RRDAC_OE_BIT] ? 1'b0 :
         din_sync;
      // Reference offered to comparator and converter channel
      next_state.cmp_ref_sel = state.ctrl[`RRDAC_EN_BIT] &&
         cmp_use_ref_in;
      next_state.adc_ref_sel = state.ctrl[`RRDAC_EN_BIT] &&
         adc_use_ref_in;
      // Fixed buffer gain; off only when the field is zero
      next_state.gain = gain_sync;
      next_state.fixed_on = (gain_sync !=
         rrdac_pkg::RRDAC_GAIN_OFF);
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   // Reset clears code, disables the converter and frees the pin
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= '0;
         state.ctrl <= `RRDAC_CTRL_RST;
         state.code <= `RRDAC_CODE_RST;
      end else begin
         state <= next_state;
      end
   end

   // ****************************************************************
   // Outputs, each straight from a flip-flop
   // ****************************************************************
   assign rdata_out = state.rdata;
   assign ladder_sel_out = state.ladder;
   assign pos_fixed_out = state.pos_fixed;
   assign pos_vrefp_out = state.pos_vrefp;
   assign pos_avdd_out = state.pos_avdd;
   assign neg_vrefn_out = state.neg_vrefn;
   assign first_ref_output_pin_out = state.pin_analog;
   assign pad_driver_off_out = state.pin_analog;
   assign pad_pullup_off_out = state.pin_analog;
   assign pad_input_off_out = state.pin_analog;
   assign pad_din_out = state.pin_din;
   assign cmp_ref_sel_out = state.cmp_ref_sel;
   assign adc_ref_sel_out = state.adc_ref_sel;
   assign fixed_gain_out = state.gain;
   assign fixed_on_out = state.fixed_on;
   assign converter_on_out = state.ctrl[`RRDAC_EN_BIT];
   // sleep_in is accepted only so the system can wire it; no effect
   logic unused_sleep;
   assign unused_sleep = sleep_in;
endmodule : rrdac_top

// ==== sim/rrdac_monitor.sv ====
// Checker for the converter control block, bound to its top module.
// Assumes one clock domain and the constants header on the path.
`timescale 1ns/1ps
`include "rrdac_cfg.svh"
module rrdac_monitor (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic [`RRDAC_ADDR_W-1:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [7:0] rdata_out,
   input wire logic converter_on_out,
   input wire logic [`RRDAC_LADDER_W-1:0] ladder_sel_out,
   input wire logic pos_fixed_out,
   input wire logic pos_vrefp_out,
   input wire logic pos_avdd_out,
   input wire logic neg_vrefn_out,
   input wire logic first_ref_output_pin_out,
   input wire logic pad_driver_off_out,
   input wire logic pad_pullup_off_out,
   input wire logic pad_input_off_out,
   input wire logic pad_din_out
);
   // Reset clears everything, so nothing is judged while it is high
   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (reset_in);
   en_write_a: assert property (
      write_in && addr_in == `RRDAC_CTRL_ADDR
      |=> converter_on_out == $past(wdata_in[7])) else $error("enable lost");
   ladder_off_a: assert property (
      !converter_on_out ##1 !converter_on_out
      |-> ladder_sel_out == '0) else $error("ladder live while off");
   ladder_tap_a: assert property (
      $onehot0(ladder_sel_out))
      else $error("several ladder taps");
   pss_onehot_a: assert property (
      $onehot0({pos_fixed_out, pos_vrefp_out, pos_avdd_out}))
      else $error("two positive sources");
   neg_gate_a: assert property (
      neg_vrefn_out |-> $past(converter_on_out))
      else $error("negative pin while off");
   pad_release_a: assert property (
      {pad_driver_off_out, pad_pullup_off_out, pad_input_off_out} ==
      {3{first_ref_output_pin_out}})
      else $error("pad functions not overridden");
   pin_zero_a: assert property (
      first_ref_output_pin_out |-> !pad_din_out)
      else $error("reference pin reads one");
   read_idle_a: assert property (
      !$past(read_in) |-> rdata_out == 8'h00)
      else $error("read data outside its cycle");
endmodule : rrdac_monitor

// ==== sim/rrdac_tb_top.sv ====
// Self-checking bench for the converter control block.
// Drives the register port and pad inputs itself; no partner model.
`timescale 1ns/1ps
`include "rrdac_cfg.svh"
module rrdac_tb_top;
   logic sys_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [`RRDAC_ADDR_W-1:0] addr_in = '0;
   logic [7:0] wdata_in = 8'h00;
   logic write_in = 1'b0, read_in = 1'b0, pad_din_in = 1'b1;
   logic sleep_in = 1'b0, cmp_use_ref_in = 1'b0, adc_use_ref_in = 1'b0;
   logic [1:0] comparator_ref_gain_in = 2'h0;
   logic [7:0] rdata_out;
   logic converter_on_out, pos_fixed_out, pos_vrefp_out, pos_avdd_out;
   logic neg_vrefn_out, first_ref_output_pin_out, pad_driver_off_out;
   logic pad_pullup_off_out, pad_input_off_out, pad_din_out;
   logic cmp_ref_sel_out, adc_ref_sel_out, fixed_on_out;
   logic [1:0] fixed_gain_out;
   logic [`RRDAC_LADDER_W-1:0] ladder_sel_out;
   int error_cnt = 0;
   int n_compared = 0;
   rrdac_top u_dut (.*);
   // 50 MHz system clock
   always #10 sys_clk_in = ~sys_clk_in;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge sys_clk_in);
      write_in <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge sys_clk_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge sys_clk_in);
      read_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : settle
   task automatic results;
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // Watchdog, far beyond the hundred or so cycles the tests take
   initial begin
      #100000;
      error_cnt++;
      results();
   end
   initial begin
      repeat (6) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rd(`RRDAC_CTRL_ADDR, 8'h00);
      rd(`RRDAC_CODE_ADDR, 8'h00);
      wr(`RRDAC_CTRL_ADDR, 8'hFF);
      wr(`RRDAC_CODE_ADDR, 8'hFF);
      settle(2);
      chk(converter_on_out, 1);
      chk(first_ref_output_pin_out, 1);
      chk({pad_driver_off_out, pad_pullup_off_out}, 2'h3);
      chk({pad_input_off_out, pad_din_out}, 2'h2);
      chk({pos_fixed_out, pos_vrefp_out, pos_avdd_out}, 3'h0);
      chk(neg_vrefn_out, 1);
      chk(ladder_sel_out, 32'h8000_0000);
      rd(`RRDAC_CTRL_ADDR, 8'hAD);
      rd(`RRDAC_CODE_ADDR, 8'h1F);
      rd(12'hEC5, 8'h00);
      // Each defined positive source in turn
      for (int p = 0; p < 3; p++) begin
         wr(`RRDAC_CTRL_ADDR, 8'h80 | 8'(p << 2));
         settle(2);
         chk({pos_fixed_out, pos_vrefp_out, pos_avdd_out},
            3'h1 << p);
      end
      chk(neg_vrefn_out, 0);
      for (int c = 0; c < 32; c += 5) begin
         wr(`RRDAC_CODE_ADDR, 8'(c));
         settle(2);
         chk(ladder_sel_out, 32'h1 << c);
      end
      // Gain input crosses a synchroniser, hence the longer wait
      for (int g = 0; g < 4; g++) begin
         @(posedge sys_clk_in);
         comparator_ref_gain_in <= 2'(g);
         settle(4);
         chk({fixed_gain_out, fixed_on_out},
            {2'(g), 1'(g != 0)});
      end
      @(posedge sys_clk_in);
      sleep_in <= 1'b1;
      cmp_use_ref_in <= 1'b1;
      adc_use_ref_in <= 1'b1;
      settle(3);
      chk({cmp_ref_sel_out, adc_ref_sel_out}, 2'h3);
      chk(converter_on_out, 1);
      rd(`RRDAC_CTRL_ADDR, 8'h88);
      wr(`RRDAC_CTRL_ADDR, 8'h00);
      settle(2);
      chk(pad_din_out, 1);
      chk({cmp_ref_sel_out, adc_ref_sel_out}, 2'h0);
      chk(ladder_sel_out, 32'h0);
      // A low pad must also come through while the pin is digital
      @(posedge sys_clk_in);
      pad_din_in <= 1'b0;
      settle(4);
      chk(pad_din_out, 0);
      // Reset in mid-run with the pin attached
      wr(`RRDAC_CTRL_ADDR, 8'hA1);
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rd(`RRDAC_CODE_ADDR, 8'h00);
      chk({converter_on_out, first_ref_output_pin_out}, 2'h0);
      rd(`RRDAC_CTRL_ADDR, 8'h00);
      results();
   end
endmodule : rrdac_tb_top
bind rrdac_top rrdac_monitor u_mon (.*);
